// ---- logic/pts_pkg.sv ----
// constants, modes and states of the parameter-table sequencer
`default_nettype none
package pts_pkg;
    // =========================================================
    // widths
    localparam int ADDR_W = 15;
    localparam int WORD_W = 12;
    localparam int WIDE_W = 24;
    // =========================================================
    // table word positions, counted from the table pointer
    localparam logic [2:0] TBL_FIELD = 3'h0;
    localparam logic [2:0] TBL_PC = 3'h1;
    localparam logic [2:0] TBL_XBASE = 3'h2;
    localparam logic [2:0] TBL_BASE = 3'h3;
    localparam logic [2:0] TBL_OPADDR = 3'h4;
    localparam logic [2:0] TBL_EXP = 3'h5;
    localparam logic [2:0] TBL_HIGH = 3'h6;
    localparam logic [2:0] TBL_LOW = 3'h7;
    // =========================================================
    // instruction fields
    localparam logic [2:0] OPC_LOAD = 3'h0;
    localparam logic [2:0] OPC_STORE = 3'h6;
    localparam logic [1:0] FORM_DIRECT = 2'h2;
    localparam logic [11:0] EXIT_WORD = 12'h000;
    // =========================================================
    // index multipliers per mode
    localparam logic [3:0] SCALE_FIXED = 4'h2;
    localparam logic [3:0] SCALE_FLOAT = 4'h3;
    localparam logic [3:0] SCALE_EXT = 4'h6;
    // =========================================================
    // reset values
    localparam logic [14:0] ADDR_RST = 15'h0000;
    localparam logic [11:0] WORD_RST = 12'h000;
    // =========================================================
    // arithmetic mode from command bits 1:0
    typedef enum logic [1:0] {
        MODE_FLOAT = 2'b00,
        MODE_FIXED = 2'b01,
        MODE_EXT = 2'b10,
        MODE_SPARE = 2'b11
    } pts_mode_t;
    // =========================================================
    // sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_LOAD = 4'b0001,
        ST_FETCH1 = 4'b0010,
        ST_FETCH2 = 4'b0011,
        ST_IDXRD = 4'b0100,
        ST_IDXWR = 4'b0101,
        ST_OPER = 4'b0110,
        ST_DUMP = 4'b0111
    } pts_state_t;
endpackage
`default_nettype wire

// ---- logic/pts_seq.sv ----
// parameter-table sequencer with indexed address generation
`timescale 1ns/1ps
`default_nettype none
// Contract
// - save state to table before interrupting host
// - addresses carry across page and field
// - load table words except word four
// - after last word fetch at program counter
// - second digit four: two-word data reference
// - zero index select means no indexing
// - two operand breaks in fixed mode, three otherwise, then next instruction
// - dump table from word seven down
// - dump order: accumulator, pointers, pc, field
// - flag only after last dump write
// - scale index by operand size (extended mode scales by six while moving three operand words)
// - add in 24 bits, keep 15
// - index n read at index base pointer plus n
// - auto-increment written back before use
// - skip host only when start accepted
// - exit clears the run flip-flop
// - host halt aborts after current instruction
module pts_seq (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic command_load_iot_in,
    input wire logic [pts_pkg::WORD_W-1:0] command_data_in,
    input wire logic start_iot_in,
    input wire logic [pts_pkg::ADDR_W-1:0] table_ptr_in,
    input wire logic halt_request_iot_in,
    input wire logic flag_clear_in,
    input wire logic mem_ack_in,
    input wire logic [pts_pkg::WORD_W-1:0] mem_rdata_in,
    output logic mem_req_out,
    output logic mem_we_out,
    output logic [pts_pkg::ADDR_W-1:0] mem_addr_out,
    output logic [pts_pkg::WORD_W-1:0] mem_wdata_out,
    output logic start_skip_out,
    output logic interrupt_skip_out,
    output logic run_out
);
    import pts_pkg::*;

    // =========================================================
    // state
    pts_state_t state_reg;
    logic [2:0] idx_reg;
    logic [2:0] opw_reg;
    logic [ADDR_W-1:0] table_ptr_reg;
    logic [ADDR_W-1:0] coproc_program_counter_reg;
    logic [ADDR_W-1:0] index_base_pointer_reg;
    logic [ADDR_W-1:0] base_reg;
    logic [ADDR_W-1:0] operand_addr_reg;
    logic [ADDR_W-1:0] addr_field_reg;
    logic [WORD_W-1:0] exp_reg;
    logic [WORD_W-1:0] high_word_reg;
    logic [WORD_W-1:0] low_word_reg;
    logic [WORD_W-1:0] instr_reg;
    logic [WORD_W-1:0] index_val_reg;
    logic [WORD_W-1:0] command_reg;
    logic halt_pend_reg;
    logic mem_req_reg;
    logic mem_we_reg;
    logic [ADDR_W-1:0] mem_addr_reg;
    logic [WORD_W-1:0] mem_wdata_reg;
    logic start_skip_reg;
    logic interrupt_skip_reg;
    logic run_reg;

    // =========================================================
    // combinational helpers
    pts_mode_t mode;
    logic [3:0] scale;
    logic [2:0] oper_last;
    logic done;
    logic [2:0] load_next;
    logic [WIDE_W-1:0] scaled_index;
    logic [WIDE_W-1:0] wide_sum;
    logic [ADDR_W-1:0] eff_addr;
    logic [ADDR_W-1:0] fetch2_field;
    logic [WORD_W-1:0] index_next;
    logic [WORD_W-1:0] dump_word;
    logic [2:0] dump_pos;

    assign done = mem_req_reg && mem_ack_in;
    assign mode = pts_mode_t'(command_reg[1:0]);

    // index multiplier per mode: two fixed, six extended, three otherwise
    always_comb
    begin
        case (mode)
            MODE_FIXED: scale = SCALE_FIXED;
            MODE_EXT: scale = SCALE_EXT;
            default: scale = SCALE_FLOAT;
        endcase
    end
    assign oper_last = (mode == MODE_FIXED) ? 3'h1 : 3'h2;

    // next table word to read, word four skipped
    assign load_next = (idx_reg == TBL_BASE) ? TBL_EXP : idx_reg + 3'h1;

    // effective address: sign-extended index times size, 24-bit sum, low 15 kept
    assign scaled_index = WIDE_W'({{(WIDE_W-WORD_W){index_val_reg[WORD_W-1]}},
        index_val_reg} * {20'h0_0000, scale});
    assign wide_sum = scaled_index + {9'h000, addr_field_reg};
    assign eff_addr = wide_sum[ADDR_W-1:0];
    assign fetch2_field = {instr_reg[2:0], mem_rdata_in};
    assign index_next = instr_reg[6] ? mem_rdata_in + 12'h001 : mem_rdata_in;

    // dump word for the next table position down, staged ahead of its write
    assign dump_pos = idx_reg - 3'h1;
    always_comb
    begin
        case (dump_pos)
            TBL_FIELD: dump_word = {operand_addr_reg[14:12], base_reg[14:12],
                index_base_pointer_reg[14:12], coproc_program_counter_reg[14:12]};
            TBL_PC: dump_word = coproc_program_counter_reg[11:0];
            TBL_XBASE: dump_word = index_base_pointer_reg[11:0];
            TBL_BASE: dump_word = base_reg[11:0];
            TBL_OPADDR: dump_word = operand_addr_reg[11:0];
            TBL_EXP: dump_word = exp_reg;
            TBL_HIGH: dump_word = high_word_reg;
            default: dump_word = low_word_reg;
        endcase
    end

    // =========================================================
    // command register
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
            command_reg <= WORD_RST;
        else if (command_load_iot_in)
            command_reg <= command_data_in;
    end

    // =========================================================
    // sequencer and memory break requests
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            state_reg <= ST_IDLE;
            idx_reg <= TBL_FIELD;
            opw_reg <= 3'h0;
            mem_req_reg <= 1'b0;
            mem_we_reg <= 1'b0;
            mem_addr_reg <= ADDR_RST;
            mem_wdata_reg <= WORD_RST;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    if (start_iot_in)
                    begin
                        state_reg <= ST_LOAD;
                        idx_reg <= TBL_FIELD;
                        mem_req_reg <= 1'b1;
                        mem_we_reg <= 1'b0;
                        mem_addr_reg <= table_ptr_in;
                    end
                end
                ST_LOAD:
                begin
                    if (done && idx_reg == TBL_LOW)
                    begin
                        state_reg <= ST_FETCH1;
                        mem_addr_reg <= coproc_program_counter_reg;
                    end
                    else if (done)
                    begin
                        idx_reg <= load_next;
                        mem_addr_reg <= table_ptr_reg + {12'h000, load_next};
                    end
                end
                ST_FETCH1:
                begin
                    if (done && mem_rdata_in == EXIT_WORD)
                    begin
                        state_reg <= ST_DUMP;
                        mem_wdata_reg <= low_word_reg;
                        idx_reg <= TBL_LOW;
                        mem_we_reg <= 1'b1;
                        mem_addr_reg <= table_ptr_reg + {12'h000, TBL_LOW};
                    end
                    else if (done && mem_rdata_in[8:7] == FORM_DIRECT)
                    begin
                        state_reg <= ST_FETCH2;
                        mem_addr_reg <= coproc_program_counter_reg + 15'h0001;
                    end
                    else if (done && halt_pend_reg)
                    begin
                        state_reg <= ST_DUMP;
                        mem_wdata_reg <= low_word_reg;
                        idx_reg <= TBL_LOW;
                        mem_we_reg <= 1'b1;
                        mem_addr_reg <= table_ptr_reg + {12'h000, TBL_LOW};
                    end
                    else if (done)
                        mem_addr_reg <= coproc_program_counter_reg + 15'h0001;
                end
                ST_FETCH2:
                begin
                    if (done && instr_reg[5:3] == 3'h0)
                    begin
                        state_reg <= ST_OPER;
                        opw_reg <= 3'h0;
                        mem_we_reg <= (instr_reg[11:9] == OPC_STORE);
                        mem_wdata_reg <= (mode == MODE_FIXED) ? high_word_reg : exp_reg;
                        mem_addr_reg <= fetch2_field;
                    end
                    else if (done)
                    begin
                        state_reg <= ST_IDXRD;
                        mem_addr_reg <= index_base_pointer_reg + {12'h000, instr_reg[5:3]};
                    end
                end
                ST_IDXRD:
                begin
                    if (done && instr_reg[6])
                    begin
                        state_reg <= ST_IDXWR;
                        mem_we_reg <= 1'b1;
                        mem_wdata_reg <= index_next;
                    end
                    else if (done)
                    begin
                        state_reg <= ST_OPER;
                        opw_reg <= 3'h0;
                        mem_req_reg <= 1'b0;
                    end
                end
                ST_IDXWR:
                begin
                    if (done)
                    begin
                        state_reg <= ST_OPER;
                        opw_reg <= 3'h0;
                        mem_we_reg <= 1'b0;
                        mem_req_reg <= 1'b0;
                    end
                end
                ST_OPER:
                begin
                    // one idle cycle after indexing lets the scaled address settle
                    if (!mem_req_reg)
                    begin
                        mem_req_reg <= 1'b1;
                        mem_we_reg <= (instr_reg[11:9] == OPC_STORE);
                        mem_wdata_reg <= (mode == MODE_FIXED) ? high_word_reg : exp_reg;
                        mem_addr_reg <= eff_addr;
                    end
                    else if (done && opw_reg == oper_last && halt_pend_reg)
                    begin
                        state_reg <= ST_DUMP;
                        // a load ending here lands in the low word at this same edge
                        mem_wdata_reg <= (instr_reg[11:9] == OPC_LOAD) ? mem_rdata_in : low_word_reg;
                        idx_reg <= TBL_LOW;
                        mem_we_reg <= 1'b1;
                        mem_addr_reg <= table_ptr_reg + {12'h000, TBL_LOW};
                    end
                    else if (done && opw_reg == oper_last)
                    begin
                        state_reg <= ST_FETCH1;
                        mem_we_reg <= 1'b0;
                        mem_addr_reg <= coproc_program_counter_reg;
                    end
                    else if (done)
                    begin
                        opw_reg <= opw_reg + 3'h1;
                        mem_addr_reg <= mem_addr_reg + 15'h0001;
                        mem_wdata_reg <= (opw_reg == oper_last - 3'h1) ? low_word_reg
                            : high_word_reg;
                    end
                end
                ST_DUMP:
                begin
                    if (done && idx_reg == TBL_FIELD)
                    begin
                        state_reg <= ST_IDLE;
                        mem_req_reg <= 1'b0;
                        mem_we_reg <= 1'b0;
                    end
                    else if (done)
                    begin
                        idx_reg <= idx_reg - 3'h1;
                        mem_addr_reg <= table_ptr_reg + {12'h000, idx_reg - 3'h1};
                        mem_wdata_reg <= dump_word;
                    end
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                    mem_req_reg <= 1'b0;
                end
            endcase
        end
    end


    // =========================================================
    // table registers and accumulator
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            table_ptr_reg <= ADDR_RST;
            coproc_program_counter_reg <= ADDR_RST;
            index_base_pointer_reg <= ADDR_RST;
            base_reg <= ADDR_RST;
            operand_addr_reg <= ADDR_RST;
            addr_field_reg <= ADDR_RST;
            exp_reg <= WORD_RST;
            high_word_reg <= WORD_RST;
            low_word_reg <= WORD_RST;
            instr_reg <= WORD_RST;
            index_val_reg <= WORD_RST;
        end
        else
        begin
            if (state_reg == ST_IDLE && start_iot_in)
                table_ptr_reg <= table_ptr_in;
            if (state_reg == ST_LOAD && done)
            begin
                case (idx_reg)
                    TBL_FIELD:
                    begin
                        coproc_program_counter_reg[14:12] <= mem_rdata_in[2:0];
                        index_base_pointer_reg[14:12] <= mem_rdata_in[5:3];
                        base_reg[14:12] <= mem_rdata_in[8:6];
                    end
                    TBL_PC: coproc_program_counter_reg[11:0] <= mem_rdata_in;
                    TBL_XBASE: index_base_pointer_reg[11:0] <= mem_rdata_in;
                    TBL_BASE: base_reg[11:0] <= mem_rdata_in;
                    TBL_EXP: exp_reg <= mem_rdata_in;
                    TBL_HIGH: high_word_reg <= mem_rdata_in;
                    default: low_word_reg <= mem_rdata_in;
                endcase
            end
            if ((state_reg == ST_FETCH1 || state_reg == ST_FETCH2) && done)
                coproc_program_counter_reg <= coproc_program_counter_reg + 15'h0001;
            if (state_reg == ST_FETCH1 && done)
                instr_reg <= mem_rdata_in;
            if (state_reg == ST_FETCH2 && done)
            begin
                addr_field_reg <= fetch2_field;
                index_val_reg <= WORD_RST;
                operand_addr_reg <= fetch2_field;
            end
            if (state_reg == ST_IDXRD && done)
                index_val_reg <= index_next;
            if (state_reg == ST_OPER && !mem_req_reg)
                operand_addr_reg <= eff_addr;
            if (state_reg == ST_OPER && done && instr_reg[11:9] == OPC_LOAD)
            begin
                if (mode != MODE_FIXED && opw_reg == 3'h0)
                    exp_reg <= mem_rdata_in;
                else if (opw_reg == oper_last)
                    low_word_reg <= mem_rdata_in;
                else
                    high_word_reg <= mem_rdata_in;
            end
        end
    end

    // =========================================================
    // host flags: start skip, run, halt, interrupt-skip
    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            start_skip_reg <= 1'b0;
            run_reg <= 1'b0;
            halt_pend_reg <= 1'b0;
            interrupt_skip_reg <= 1'b0;
        end
        else
        begin
            start_skip_reg <= (state_reg == ST_IDLE) && start_iot_in;
            if (state_reg == ST_IDLE && start_iot_in)
                run_reg <= 1'b1;
            else if (state_reg == ST_DUMP && done && idx_reg == TBL_FIELD)
                run_reg <= 1'b0;
            if (halt_request_iot_in)
                halt_pend_reg <= 1'b1;
            else if (state_reg == ST_DUMP)
                halt_pend_reg <= 1'b0;
            if (state_reg == ST_DUMP && done && idx_reg == TBL_FIELD)
                interrupt_skip_reg <= 1'b1;
            else if (flag_clear_in || (state_reg == ST_IDLE && start_iot_in))
                interrupt_skip_reg <= 1'b0;
        end
    end

    assign mem_req_out = mem_req_reg;
    assign mem_we_out = mem_we_reg;
    assign mem_addr_out = mem_addr_reg;
    assign mem_wdata_out = mem_wdata_reg;
    assign start_skip_out = start_skip_reg;
    assign interrupt_skip_out = interrupt_skip_reg;
    assign run_out = run_reg;

    // =========================================================
    // checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    sequence dump_last;
        state_reg == ST_DUMP && done && idx_reg == TBL_FIELD;
    endsequence

    sequence dump_entry;
        state_reg != ST_DUMP ##1 state_reg == ST_DUMP;
    endsequence

    a_flag_after_dump: assert property ($rose(interrupt_skip_reg) |->
        $past(state_reg) == ST_DUMP && $past(idx_reg) == TBL_FIELD && $past(done))
        else $error("flag before dump");
    a_dump_then_flag: assert property (dump_last |=> interrupt_skip_reg && !run_reg)
        else $error("dump end lacks flag or run");
    a_load_skips_four: assert property (state_reg == ST_LOAD |-> idx_reg != TBL_OPADDR)
        else $error("word four loaded");
    a_first_fetch_pc: assert property (state_reg == ST_LOAD && done && idx_reg == TBL_LOW
        |=> mem_addr_reg == coproc_program_counter_reg) else $error("bad first fetch");
    a_dump_descends: assert property (state_reg == ST_DUMP && done && idx_reg != TBL_FIELD
        |=> idx_reg == $past(idx_reg) - 3'h1) else $error("dump not descending");
    a_dump_addr_table: assert property (state_reg == ST_DUMP |-> mem_we_reg
        && mem_addr_reg == table_ptr_reg + {12'h000, idx_reg}) else $error("dump addr");
    a_skip_on_accept: assert property (start_iot_in && state_reg != ST_IDLE
        |=> !start_skip_reg) else $error("skip while busy");
    a_no_index_direct: assert property (state_reg == ST_FETCH2 && done
        && instr_reg[5:3] == 3'h0 |=> mem_addr_reg == $past(fetch2_field))
        else $error("unindexed address changed");
    a_index_addr: assert property (state_reg == ST_FETCH2 && done
        && instr_reg[5:3] != 3'h0
        |=> mem_addr_reg == index_base_pointer_reg + {12'h000, instr_reg[5:3]})
        else $error("index word address");
    a_dump_starts_low: assert property (dump_entry |-> mem_wdata_reg == low_word_reg)
        else $error("dump word seven data");
endmodule
`default_nettype wire

// ---- bench/pts_host_mem.sv ----
// host core memory answering data breaks with varying latency
`timescale 1ns/1ps
`default_nettype none
module pts_host_mem (
    input wire logic clk_in,
    input wire logic req_in,
    input wire logic we_in,
    input wire logic [14:0] addr_in,
    input wire logic [11:0] wdata_in,
    output logic ack_out,
    output logic [11:0] rdata_out
);
    logic [11:0] mem_arr [0:32767];
    logic [1:0] wait_reg = 2'h0;
    logic [3:0] lat_reg = 4'h9;
    initial ack_out = 1'b0;
    initial rdata_out = 12'h000;
    // one ack per break; read data turns over whenever it is not valid
    always @(posedge clk_in)
    begin
        ack_out <= 1'b0;
        rdata_out <= ~rdata_out;
        if (req_in && !ack_out)
        begin
            if (wait_reg != 2'h0)
                wait_reg <= wait_reg - 2'h1;
            else
            begin
                ack_out <= 1'b1;
                if (we_in)
                    mem_arr[addr_in] <= wdata_in;
                else
                    rdata_out <= mem_arr[addr_in];
                lat_reg <= {lat_reg[2:0], lat_reg[3] ^ lat_reg[2]};
                wait_reg <= lat_reg[1:0];
            end
        end
    end
endmodule
`default_nettype wire

// ---- bench/pts_seq_test.sv ----
// self-checking bench for the parameter-table sequencer
`timescale 1ns/1ps
`default_nettype none
module pts_seq_test;
    import pts_pkg::*;
    logic clk = 1'b0, rst = 1'b1, cld = 1'b0, start = 1'b0, halt = 1'b0, fclr = 1'b0;
    logic [11:0] cmd = 12'h000;
    logic [14:0] ptr = 15'h0fff;
    logic ack, req, we, skip, irq, run;
    logic [11:0] rdata, wdata;
    logic [14:0] addr;
    logic [27:0] exp_q[$];
    logic [31:0] seed = 32'h0001_7544;
    logic [11:0] ac [3];
    logic [11:0] tbl [8] = '{12'h008, 12'h200, 12'h803, 12'h800, 12'h000, 12'h053, 12'h977, 12'hfac};
    logic [11:0] prog [5] = '{12'h101, 12'h403, 12'h169, 12'h403, 12'h000};
    int ea;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    // 50 MHz system clock
    initial forever #10 clk = ~clk;
    pts_seq dut (.clk_sys_in(clk), .rst_in(rst), .command_load_iot_in(cld),
        .command_data_in(cmd), .start_iot_in(start), .table_ptr_in(ptr),
        .halt_request_iot_in(halt), .flag_clear_in(fclr), .mem_ack_in(ack),
        .mem_rdata_in(rdata), .mem_req_out(req), .mem_we_out(we), .mem_addr_out(addr),
        .mem_wdata_out(wdata), .start_skip_out(skip), .interrupt_skip_out(irq),
        .run_out(run));
    pts_host_mem mem (.clk_in(clk), .req_in(req), .we_in(we), .addr_in(addr),
        .wdata_in(wdata), .ack_out(ack), .rdata_out(rdata));
    task automatic check(input logic [27:0] seen, input logic [27:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            fail_count++;
            $display("MISMATCH at %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic end_sim();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    function automatic void xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
    endfunction
    task automatic push(input logic w, input int a, input logic [11:0] d);
        exp_q.push_back({w, 15'(a), w ? d : 12'h000});
    endtask
    // operand breaks: loads fill the accumulator from its high end, stores write it out
    task automatic oper(input int n, input logic st);
        for (int j = 0; j < n; j++)
        begin
            push(st, ea + j, ac[3 - n + j]);
            if (!st)
                ac[3 - n + j] = mem.mem_arr[15'(ea + j)];
        end
    endtask
    // one program: direct load, indexed load or store, exit
    task automatic run_prog(input int mode, input logic hlt);
        int m;
        int n;
        int v;
        int pc;
        logic [11:0] op;
        m = (mode == 1) ? 2 : (mode == 2) ? 6 : 3;
        n = (mode == 1) ? 2 : 3;
        xs();
        v = int'($signed(seed[6:0]));
        for (int k = 0; k < 8; k++) mem.mem_arr[15'(ptr + k)] = tbl[k];
        for (int k = 0; k < 5; k++) mem.mem_arr[15'h0200 + k] = prog[k];
        // indexed word: load with increment, load without, or store with increment
        op = (mode == 2) ? 12'hd69 : (mode == 1) ? 12'h129 : 12'h169;
        mem.mem_arr[15'h0202] = op;
        mem.mem_arr[15'h1808] = 12'(v);
        ac = '{tbl[5], tbl[6], tbl[7]};
        ea = 32'h1403;
        for (int k = 0; k < 8; k++) if (k != 4) push(1'b0, ptr + k, 12'h000);
        push(1'b0, 32'h200, 12'h000);
        push(1'b0, 32'h201, 12'h000);
        oper(n, 1'b0);
        pc = 32'h202;
        if (!hlt)
        begin
            push(1'b0, 32'h202, 12'h000);
            push(1'b0, 32'h203, 12'h000);
            push(1'b0, 32'h1808, 12'h000);
            if (op[6])
                push(1'b1, 32'h1808, 12'(v + 1));
            v = v + int'(op[6]);
            ea = (32'h1403 + m * v) & 32'h7fff;
            oper(n, op[11]);
            push(1'b0, 32'h204, 12'h000);
            pc = 32'h205;
        end
        push(1'b1, ptr + 7, ac[2]);
        push(1'b1, ptr + 6, ac[1]);
        push(1'b1, ptr + 5, ac[0]);
        push(1'b1, ptr + 4, ea[11:0]);
        push(1'b1, ptr + 3, tbl[3]);
        push(1'b1, ptr + 2, tbl[2]);
        push(1'b1, ptr + 1, pc[11:0]);
        push(1'b1, ptr, {ea[14:12], 6'h01, pc[14:12]});
        @(posedge clk);
        cmd <= 12'(mode);
        cld <= 1'b1;
        halt <= hlt;
        fclr <= 1'b1;
        @(posedge clk);
        cld <= 1'b0;
        halt <= 1'b0;
        fclr <= 1'b0;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        #1 check(28'(skip), 28'h1);
        check(28'(irq), 28'h0);
        @(posedge clk);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        #1 check(28'(skip), 28'h0);
        for (int i = 0; i < 3000 && irq !== 1'b1; i++) #20;
        check(28'(exp_q.size()), 28'h0);
        check(28'({run, irq}), 28'h1);
    endtask
    // each completed break is compared with the next expected one
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            end_sim();
        end
        else if (req && ack)
            check({we, addr, we ? wdata : 12'h000},
                exp_q.size() ? exp_q.pop_front() : '1);
    end
    initial
    begin
        for (int a = 0; a < 32768; a++) mem.mem_arr[a] = 12'(a) ^ 12'ha5a;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 4; k++) run_prog(k, k == 3);
        end_sim();
    end
endmodule
`default_nettype wire
